//--- src/rx_emd_suppression_config.sv
// rx disturbance suppression, subcarrier start timer and channel select
// assumes a synchronous decoder event stream and 0.25 etu ticks from outside
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module rx_emd_suppression_config
  import rx_emd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rx_evt_s rx_evt,
  input wire logic type_a_106k,
  input wire logic type_b_106k,
  input wire logic quarter_etu_tick,
  input wire logic mask_receive_timer_done,
  input wire logic subcarrier_detect,
  input wire logic crc_error,
  output logic rx_started,
  output logic frame_discard,
  output logic crc_check_en,
  output logic rx_channel_select,
  output logic am_channel_en,
  output logic pm_channel_en,
  output logic framing_from_pm,
  output logic [2:0] lowpass_setting,
  output logic [3:0] zero_cfg,
  output logic irq
);

  // ==========================================================
  // register bus
  // ==========================================================
  logic [7:0] emd_cfg_q, sc_start_q, rxcfg1_q, opctl_q, rxopt_q;
  logic [7:0] irq_stat_q, irq_mask_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic aw_held_q, w_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] bresp_q;
  logic bvalid_q, rvalid_q;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_LSB];
  endfunction : reg_index

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] i;
    i = a[ADDR_W-1:IDX_LSB];
    return i == IDX_EMD_CFG || i == IDX_SC_START || i == IDX_RXCFG1 ||
      i == IDX_OPCTL || i == IDX_IRQ_STAT || i == IDX_IRQ_MASK ||
      i == IDX_RXOPT;
  endfunction : mapped

  // take a channel only when its ready is offered, never under a response
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_q || s_axi_awvalid;
  wire w_have = w_held_q || s_axi_wvalid;
  wire wr_fire = aw_have && w_have && !bvalid_q;
  wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_data = w_held_q ? wdata_q : s_axi_wdata[7:0];
  wire wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  wire wr_en = wr_fire && wr_lane0 && mapped(wr_addr);
  wire [3:0] wr_idx = reg_index(wr_addr);
  wire rd_fire = s_axi_arvalid && !rvalid_q;
  wire [3:0] rd_idx = reg_index(s_axi_araddr);
  wire rd_stat = rd_fire && rd_idx == IDX_IRQ_STAT;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else begin
      aw_held_q <= aw_take && !wr_fire ? 1'b1 : (wr_fire ? 1'b0 : aw_held_q);
      w_held_q <= w_take && !wr_fire ? 1'b1 : (wr_fire ? 1'b0 : w_held_q);
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire && !(aw_take && !s_axi_awready)) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // reserved bits masked on write read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emd_cfg_q <= REG_RESET;
      sc_start_q <= REG_RESET;
      rxcfg1_q <= REG_RESET;
      opctl_q <= REG_RESET;
      rxopt_q <= REG_RESET;
      irq_mask_q <= REG_RESET;
    end else if (wr_en) begin
      if (wr_idx == IDX_EMD_CFG) emd_cfg_q <= wr_data & EMD_CFG_WMASK;
      if (wr_idx == IDX_SC_START) sc_start_q <= wr_data & SC_START_WMASK;
      if (wr_idx == IDX_RXCFG1) rxcfg1_q <= wr_data & RXCFG1_WMASK;
      if (wr_idx == IDX_OPCTL) opctl_q <= wr_data & OPCTL_WMASK;
      if (wr_idx == IDX_RXOPT) rxopt_q <= wr_data & RXOPT_WMASK;
      if (wr_idx == IDX_IRQ_MASK) irq_mask_q <= wr_data & IRQ_WMASK;
    end
  end

  logic [7:0] rd_val;
  always_comb begin
    unique case (rd_idx)
      IDX_EMD_CFG: rd_val = emd_cfg_q;
      IDX_SC_START: rd_val = sc_start_q;
      IDX_RXCFG1: rd_val = rxcfg1_q;
      IDX_OPCTL: rd_val = opctl_q;
      IDX_RXOPT: rd_val = rxopt_q;
      IDX_IRQ_STAT: rd_val = irq_stat_q;
      IDX_IRQ_MASK: rd_val = irq_mask_q;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // configuration outputs
  // ==========================================================
  wire emd_en = emd_cfg_q[EMD_EN_BIT];
  wire start_any = emd_cfg_q[START_POL_BIT];
  wire [3:0] short_limit = emd_cfg_q[THLD_MSB:0];
  wire [4:0] sc_start_time = sc_start_q[SC_START_MSB:0];
  wire both_en = opctl_q[OPC_AM_BIT] && opctl_q[OPC_PM_BIT];
  wire manual_sel = opctl_q[OPC_MANUAL_BIT];
  analog_cfg_s acfg;
  assign acfg = analog_cfg_s'(rxcfg1_q);

  assign rx_channel_select = rxcfg1_q[RX_CHANNEL_SELECT_BIT];
  // single enabled channel follows the select bit
  assign am_channel_en = both_en || !rx_channel_select;
  assign pm_channel_en = both_en || rx_channel_select;
  // with both enabled and manual select, bit picks framing source
  assign framing_from_pm = (both_en && manual_sel) ? rx_channel_select
                                                   : pm_channel_en && !both_en;
  assign lowpass_setting = acfg.lowpass_setting;
  assign zero_cfg = {acfg.zero_cfg_bit3, acfg.zero_cfg_bit2,
                     acfg.zero_cfg_bit1, acfg.zero_cfg_bit0};
  assign crc_check_en = !rxopt_q[CRC_SKIP_BIT];

  // ==========================================================
  // reception start policy and frame suppression
  // ==========================================================
  logic [2:0] bitcnt_q;
  logic head_err_q, frame_err_q, started_q, in_frame_q;
  logic [3:0] bytes_q;
  wire head_done = rx_evt.bit_valid && bitcnt_q == FIRST_BITS - 3'h1;
  wire head_err_now = head_err_q || (rx_evt.bit_valid && rx_evt.bit_err);
  // policy 0 needs clean first four bits, only for type A 106k
  wire start_ok = !type_a_106k || start_any || !head_err_now;
  wire short_frame = bytes_q < short_limit;
  wire frame_bad = frame_err_q || (rx_evt.bit_valid && rx_evt.bit_err) ||
                   (crc_check_en && crc_error);
  wire emd_frame_drop = rx_evt.eof && emd_en && short_frame &&
                        frame_bad;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt_q <= 3'h0;
      head_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      started_q <= 1'b0;
      in_frame_q <= 1'b0;
      bytes_q <= 4'h0;
    end else if (rx_evt.sof) begin
      bitcnt_q <= 3'h0;
      head_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      started_q <= 1'b0;
      in_frame_q <= 1'b1;
      bytes_q <= 4'h0;
    end else if (in_frame_q) begin
      if (rx_evt.bit_valid && bitcnt_q < FIRST_BITS) bitcnt_q <= bitcnt_q + 3'h1;
      if (rx_evt.bit_valid && rx_evt.bit_err) begin
        frame_err_q <= 1'b1;
        if (bitcnt_q < FIRST_BITS) head_err_q <= 1'b1;
      end
      if (head_done && start_ok) started_q <= 1'b1;
      if (rx_evt.byte_done && bytes_q != 4'hF) bytes_q <= bytes_q + 4'h1;
      if (rx_evt.eof) in_frame_q <= 1'b0;
    end
  end
  assign rx_started = started_q;

  // ==========================================================
  // subcarrier start timer, type B 106k
  // ==========================================================
  logic armed_q;
  logic [4:0] quarter_q;
  // elapsed quarter etu since mask timer end against start time
  wire start_violation = armed_q && type_b_106k && subcarrier_detect &&
                         quarter_q < sc_start_time;
  wire ev_soft = start_violation && !emd_en;
  wire ev_restart = start_violation && emd_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      quarter_q <= 5'h00;
    end else if (mask_receive_timer_done) begin
      armed_q <= 1'b1;
      quarter_q <= 5'h00;
    end else if (subcarrier_detect) begin
      armed_q <= 1'b0;
    end else if (armed_q && quarter_etu_tick && quarter_q != 5'h1F) begin
      quarter_q <= quarter_q + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) frame_discard <= 1'b0;
    else frame_discard <= emd_frame_drop || ev_restart;
  end

  // ==========================================================
  // interrupts: sticky, read clears, set wins over clear
  // ==========================================================
  logic [7:0] irq_set;
  always_comb begin
    irq_set = 8'h00;
    irq_set[IRQ_SOFT] = ev_soft;
    irq_set[IRQ_RESTART] = ev_restart || emd_frame_drop;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat_q <= REG_RESET;
    else irq_stat_q <= ((rd_stat ? 8'h00 : irq_stat_q) | irq_set) & IRQ_WMASK;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule : rx_emd_suppression_config

//--- src/rx_emd_pkg.sv
// package: register map, field positions and types for the rx emd block
// assumes a 32-bit axi4-lite register bus, one register per aligned word
package rx_emd_pkg;
  localparam int ADDR_W = 6;
  // printed offsets are register indices; byte address is four times these
  localparam logic [3:0] IDX_EMD_CFG = 4'h5;
  localparam logic [3:0] IDX_SC_START = 4'h6;
  localparam logic [3:0] IDX_RXCFG1 = 4'hB;
  localparam logic [3:0] IDX_OPCTL = 4'h0;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h1;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h2;
  localparam logic [3:0] IDX_RXOPT = 4'h3;
  localparam int EMD_EN_BIT = 7;
  localparam int START_POL_BIT = 6;
  localparam int THLD_MSB = 3;
  localparam int SC_START_MSB = 4;
  localparam int RX_CHANNEL_SELECT_BIT = 7;
  localparam int OPC_AM_BIT = 0;
  localparam int OPC_PM_BIT = 1;
  localparam int OPC_MANUAL_BIT = 2;
  localparam int CRC_SKIP_BIT = 1;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] EMD_CFG_WMASK = 8'hCF;
  localparam logic [7:0] SC_START_WMASK = 8'h1F;
  localparam logic [7:0] RXCFG1_WMASK = 8'hFF;
  localparam logic [7:0] OPCTL_WMASK = 8'h07;
  localparam logic [7:0] RXOPT_WMASK = 8'h07;
  localparam logic [7:0] IRQ_WMASK = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int IRQ_SOFT = 0;
  localparam int IRQ_RESTART = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] FIRST_BITS = 3'h4;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] lowpass_setting;
    logic zero_cfg_bit3;
    logic zero_cfg_bit2;
    logic zero_cfg_bit1;
    logic zero_cfg_bit0;
  } analog_cfg_s;

  typedef struct packed {
    logic sof;
    logic bit_valid;
    logic bit_err;
    logic byte_done;
    logic eof;
  } rx_evt_s;
endpackage : rx_emd_pkg

//--- tb/rx_emd_props.sv
// checker: bus answers and register-to-pin relations of the rx emd block
// assumes write address and data are offered together
`timescale 1ns/10ps
module rx_emd_props
  import rx_emd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire rx_evt_s rx_evt,
  input wire logic rx_started,
  input wire logic frame_discard,
  input wire logic crc_check_en,
  input wire logic rx_channel_select,
  input wire logic [2:0] lowpass_setting,
  input wire logic [3:0] zero_cfg
);
  // ==========================================================
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire both_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire wr_go = both_go && s_axi_wstrb[0];
  wire wr_cfg1 = wr_go && s_axi_awaddr == {IDX_RXCFG1, 2'b00};
  wire wr_opt = wr_go && s_axi_awaddr == {IDX_RXOPT, 2'b00};
  lowpass_map_a: assert property (wr_cfg1 |=>
    lowpass_setting == $past(s_axi_wdata[6:4])) else $error("lowpass bad");
  zero_map_a: assert property (wr_cfg1 |=>
    zero_cfg == $past(s_axi_wdata[3:0])) else $error("zero cfg bad");
  sel_map_a: assert property (wr_cfg1 |=>
    rx_channel_select == $past(s_axi_wdata[7])) else $error("select bad");
  crc_map_a: assert property (wr_opt |=>
    crc_check_en == !$past(s_axi_wdata[1])) else $error("crc check bad");
  start_clear_a: assert property (rx_evt.sof |=> !rx_started)
    else $error("start flag kept over new frame");
  drop_pulse_a: assert property (frame_discard |=> !frame_discard)
    else $error("discard longer than one cycle");
  read_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0 && !s_axi_arready) else $error("read bad");
  write_resp_a: assert property (both_go |=> s_axi_bvalid)
    else $error("write response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  cover property (frame_discard);
  cover property (wr_cfg1);
  cover property (rx_started);
endmodule : rx_emd_props
bind rx_emd_suppression_config rx_emd_props rx_emd_props_i (.*);

//--- tb/card_model.sv
// card model: decoder event stream and subcarrier timing of the far side
// assumes tasks are called right after a rising edge of aclk
`timescale 1ns/10ps
module card_model
  import rx_emd_pkg::*;
(
  input wire logic aclk,
  output rx_evt_s rx_evt,
  output logic quarter_etu_tick,
  output logic mask_receive_timer_done,
  output logic subcarrier_detect,
  output logic crc_error
);
  // ==========================================================
  // frames and subcarrier starts
  initial {rx_evt, quarter_etu_tick, mask_receive_timer_done,
    subcarrier_detect, crc_error} = '0;
  task automatic frame(input int nbytes, input logic err, input logic crc);
    @(posedge aclk);
    rx_evt <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < nbytes * 8; i++) begin
      @(posedge aclk);
      rx_evt <= '{1'b0, 1'b1, err && i == 1, i % 8 == 7, 1'b0};
    end
    @(posedge aclk);
    rx_evt <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    crc_error <= crc;
    @(posedge aclk);
    rx_evt <= '0;
    // crc level is only valid at end of frame
    crc_error <= !crc;
    repeat (3) @(posedge aclk);
  endtask : frame
  task automatic sc_start(input int ticks);
    @(posedge aclk);
    mask_receive_timer_done <= 1'b1;
    @(posedge aclk);
    mask_receive_timer_done <= 1'b0;
    repeat (ticks) begin
      @(posedge aclk);
      quarter_etu_tick <= 1'b1;
      @(posedge aclk);
      quarter_etu_tick <= 1'b0;
    end
    @(posedge aclk);
    subcarrier_detect <= 1'b1;
    @(posedge aclk);
    subcarrier_detect <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : sc_start
endmodule : card_model

//--- tb/test_rx_emd_suppression_config.sv
// bench: registers, channels, start policy, suppression, subcarrier timer
// assumes card_model stands in for the decoder and timer side
`timescale 1ns/10ps
module test_rx_emd_suppression_config;
  import rx_emd_pkg::*;
  logic aclk = 0, aresetn = 0, ta = 0, tbb = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd_v, rdata;
  logic [1:0] rs_v, rresp, bs_v, bresp;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rx_started, irq;
  logic frame_discard, crc_check_en, sel, am_en, pm_en, fr_pm;
  logic [2:0] lowpass;
  logic [3:0] zc;
  logic tick, tmr_done, scd, crc;
  rx_evt_s evt;
  int n_errors = 0, n_compared = 0, drops = 0;
  logic [5:0] addr_t [3] = '{6'h14, 6'h18, 6'h2C};
  logic [7:0] mask_t [3] = '{8'hCF, 8'h1F, 8'hFF};
  rx_emd_suppression_config rx_emd_suppression_config_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_evt(evt), .type_a_106k(ta), .type_b_106k(tbb),
    .quarter_etu_tick(tick), .mask_receive_timer_done(tmr_done),
    .subcarrier_detect(scd), .crc_error(crc), .rx_started(rx_started),
    .frame_discard(frame_discard), .crc_check_en(crc_check_en),
    .rx_channel_select(sel), .am_channel_en(am_en), .pm_channel_en(pm_en),
    .framing_from_pm(fr_pm), .lowpass_setting(lowpass), .zero_cfg(zc),
    .irq(irq));
  card_model card_model_i (.aclk(aclk), .rx_evt(evt), .quarter_etu_tick(tick),
    .mask_receive_timer_done(tmr_done), .subcarrier_detect(scd),
    .crc_error(crc));
  always #20 aclk = ~aclk;
  always @(posedge aclk) if (frame_discard === 1'b1) drops <= drops + 1;
  // ==========================================================
  // bus and report tasks
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bs_v = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    n_errors++;
    wrap_up();
  endtask : wr
  task automatic rd(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd_v = rdata;
        rs_v = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    n_errors++;
    wrap_up();
  endtask : rd
  // ==========================================================
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      rd(addr_t[i]);
      chk(rd_v, 32'h0);
      wr(addr_t[i], 8'hFF);
      rd(addr_t[i]);
      chk(rd_v, {24'h0, mask_t[i]});
    end
    chk({24'h0, sel, lowpass, zc}, 32'hFF);
    chk({30'h0, bs_v}, {30'h0, RESP_OKAY});
    rd(6'h3C);
    chk({rd_v[31:2], rs_v}, {30'h0, RESP_SLVERR});
    wr(6'h3C, 8'h55);
    chk({30'h0, bs_v}, {30'h0, RESP_SLVERR});
  endtask : t_regs
  task automatic t_chan();
    wr(6'h00, 8'h01);
    chk({30'h0, am_en, pm_en}, 32'h1);
    wr(6'h00, 8'h07);
    chk({31'h0, fr_pm}, 32'h1);
    wr(6'h2C, 8'h7F);
    chk({29'h0, am_en, pm_en, fr_pm}, 32'h6);
    wr(6'h0C, 8'h02);
    chk({31'h0, crc_check_en}, 32'h0);
    wr(6'h0C, 8'h04);
    chk({31'h0, crc_check_en}, 32'h1);
  endtask : t_chan
  task automatic t_start();
    ta <= 1'b1;
    wr(6'h14, 8'h00);
    card_model_i.frame(1, 1'b1, 1'b0);
    chk({31'h0, rx_started}, 32'h0);
    card_model_i.frame(1, 1'b0, 1'b0);
    chk({31'h0, rx_started}, 32'h1);
    wr(6'h14, 8'h40);
    card_model_i.frame(1, 1'b1, 1'b0);
    chk({31'h0, rx_started}, 32'h1);
  endtask : t_start
  task automatic t_emd();
    int d0;
    wr(6'h08, 8'h02);
    wr(6'h14, 8'hC4);
    d0 = drops;
    card_model_i.frame(2, 1'b1, 1'b0);
    chk(drops - d0, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(6'h04);
    chk(rd_v, 32'h2);
    chk({31'h0, irq}, 32'h0);
    card_model_i.frame(4, 1'b1, 1'b0);
    card_model_i.frame(3, 1'b0, 1'b1);
    chk(drops - d0, 32'h2);
    wr(6'h14, 8'h44);
    card_model_i.frame(2, 1'b1, 1'b0);
    chk(drops - d0, 32'h2);
    rd(6'h04);
    chk(rd_v, 32'h2);
  endtask : t_emd
  task automatic t_sst();
    int d0;
    ta <= 1'b0;
    tbb <= 1'b1;
    wr(6'h18, 8'h08);
    wr(6'h08, 8'h00);
    card_model_i.sc_start(7);
    chk({31'h0, irq}, 32'h0);
    rd(6'h04);
    chk(rd_v, 32'h1);
    card_model_i.sc_start(8);
    rd(6'h04);
    chk(rd_v, 32'h0);
    wr(6'h08, 8'h03);
    wr(6'h14, 8'hC4);
    d0 = drops;
    card_model_i.sc_start(3);
    chk({31'h0, irq}, 32'h1);
    rd(6'h04);
    chk(rd_v, 32'h2);
    chk(drops - d0, 32'h1);
  endtask : t_sst
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_chan();
    t_start();
    t_emd();
    t_sst();
    wrap_up();
  end
endmodule : test_rx_emd_suppression_config
